/* File: inc/slcu_pkg.sv */
// Constants and types shared by the swing, length and count unit
`default_nettype none
package slcu_pkg;

    // Clock and swing time base
    localparam int CLK_MHZ      = 250;
    localparam int TICK_TIME_US = 100;
    localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;
    localparam int TICK_W       = 16;

    // Field widths
    localparam int FREQ_W  = 16;
    localparam int PCT_W   = 10;
    localparam int TIME_W  = 15;
    localparam int CNT_W   = 16;
    localparam int PULSE_W = 32;
    localparam int SEG_W   = 25;
    localparam int SPAN_W  = 17;
    localparam int OFF_W   = 19;

    // Divider shape
    localparam int NUM_W  = 48;
    localparam int DEN_W  = 25;
    localparam int STEP_W = 6;

    // Scale factors: percent in 0.1 %, time in 0.1 s, pulses/m in 0.1
    localparam logic [DEN_W-1:0] PERMILLE      = 25'h00003E8;
    localparam logic [SEG_W-1:0] TICKS_PER_DS  =
        SEG_W'(100000 / TICK_TIME_US);
    localparam logic [NUM_W-1:0] LEN_SCALE     = 48'h00000000000A;
    localparam logic [PCT_W-1:0] SWING_PCT_MAX = 10'h3E8;
    localparam logic [PCT_W-1:0] JUMP_PCT_MAX  = 10'h1F4;
    localparam logic [PCT_W-1:0] RISE_PCT_MAX  = 10'h3E8;
    localparam logic [TIME_W-1:0] CYCLE_MAX    = 15'h7530;

    // Pin synchroniser slots
    localparam int PIN_N       = 5;
    localparam int PIN_LEN     = 0;
    localparam int PIN_CNT     = 1;
    localparam int PIN_FAST    = 2;
    localparam int PIN_LEN_RST = 3;
    localparam int PIN_CNT_RST = 4;

    // Values after reset
    localparam logic [FREQ_W-1:0]  FREQ_RST  = 16'h0000;
    localparam logic [CNT_W-1:0]   CNT_RST   = 16'h0000;
    localparam logic [PULSE_W-1:0] PULSE_RST = 32'h00000000;
    localparam logic [SEG_W-1:0]   SEG_RST   = 25'h0000000;
    localparam logic [SPAN_W-1:0]  SPAN_RST  = 17'h00000;

    // Divider job sequence
    typedef enum logic [1:0] {
        J_AW,
        J_JUMP,
        J_TRI,
        J_LEN
    } slcu_job_t;

endpackage
`default_nettype wire

/* File: rtl/slcu_divider.sv */
// Sequential restoring divider shared by the unit's arithmetic jobs
`default_nettype none
`timescale 1ns/100ps
module slcu_divider
    import slcu_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             start,
    input  wire logic [NUM_W-1:0] num,
    input  wire logic [DEN_W-1:0] den,
    output var  logic             done,
    output var  logic [NUM_W-1:0] quot
);

    logic [DEN_W:0]    rem;
    logic [DEN_W-1:0]  den_q;
    logic [STEP_W-1:0] step;
    logic              busy;

    // One quotient bit per cycle; remainder keeps one spare bit
    wire [DEN_W:0]   rem_sh   = {rem[DEN_W-1:0], quot[NUM_W-1]};
    wire             fits     = rem_sh >= {1'b0, den_q};
    wire [DEN_W:0]   next_rem = fits ? rem_sh - {1'b0, den_q} : rem_sh;
    wire [NUM_W-1:0] next_quot = {quot[NUM_W-2:0], fits};
    wire             last     = step == STEP_W'(NUM_W - 1);

    // Start is ignored while a division is running
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy  <= 1'b0;
            done  <= 1'b0;
            step  <= '0;
            rem   <= '0;
            den_q <= '0;
            quot  <= '0;
        end
        else if (start && !busy)
        begin
            busy  <= 1'b1;
            done  <= 1'b0;
            step  <= '0;
            rem   <= '0;
            den_q <= den;
            quot  <= num;
        end
        else if (busy)
        begin
            rem  <= next_rem;
            quot <= next_quot;
            step <= step + 1'b1;
            busy <= !last;
            done <= last;
        end
        else
        begin
            done <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/slcu_top.sv */
// Swing frequency generator with fixed-length and pulse counting
`default_nettype none
`timescale 1ns/100ps
// Behaviour
// - Output swings around set frequency while active
// - Zero swing amplitude gives zero excursion
// - Base select: 0 set frequency, 1 maximum
// - Swing span is base times swing percent
// - Jump frequency is span times jump percent
// - Swinging output clamped to upper/lower limits
// - One full swing period per cycle time
// - Rise takes coefficient share, fall the rest
// - Length is pulse count over pulses per metre
// - Length reached when length exceeds set length
// - Length reset input clears accumulated length
// - Count pulses on counter input
// - Set count reached flags and stops counting
// - Designated count flags, counting continues
module slcu_top
    import slcu_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
)
(
    input  wire logic              SYS_CLK,
    input  wire logic              RESETN,
    input  wire logic              RUN,
    input  wire logic              SWING_EN,
    input  wire logic              BASE_SEL,
    input  wire logic [FREQ_W-1:0] SET_FREQ,
    input  wire logic [FREQ_W-1:0] MAX_FREQ,
    input  wire logic [FREQ_W-1:0] UPPER_LIMIT,
    input  wire logic [FREQ_W-1:0] LOWER_LIMIT,
    input  wire logic [PCT_W-1:0]  SWING_AMP,
    input  wire logic [PCT_W-1:0]  JUMP_AMP,
    input  wire logic [TIME_W-1:0] CYCLE_TIME,
    input  wire logic [PCT_W-1:0]  RISE_COEF,
    input  wire logic [CNT_W-1:0]  SET_LENGTH,
    input  wire logic [CNT_W-1:0]  PULSES_PER_M,
    input  wire logic [CNT_W-1:0]  SET_COUNT,
    input  wire logic [CNT_W-1:0]  DESIG_COUNT,
    input  wire logic              LEN_FAST_SEL,
    input  wire logic              CNT_FAST_SEL,
    input  wire logic              LEN_PULSE_IN,
    input  wire logic              CNT_PULSE_IN,
    input  wire logic              FAST_PULSE_INPUT,
    input  wire logic              LEN_RESET_IN,
    input  wire logic              CNT_RESET_IN,
    output var  logic [FREQ_W-1:0] OUT_FREQ,
    output var  logic [FREQ_W-1:0] SWING_SPAN,
    output var  logic [FREQ_W-1:0] JUMP_FREQ,
    output var  logic [CNT_W-1:0]  ACTUAL_LENGTH,
    output var  logic              LENGTH_REACHED,
    output var  logic [CNT_W-1:0]  COUNT_VALUE,
    output var  logic              SET_COUNT_REACHED,
    output var  logic              DESIG_COUNT_REACHED
);

    // Pin synchronisers and edge detection
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic [PIN_N-1:0] pin_prev;
    logic [PIN_N-1:0] pin_rise;

    assign pin_raw[PIN_LEN]     = LEN_PULSE_IN;
    assign pin_raw[PIN_CNT]     = CNT_PULSE_IN;
    assign pin_raw[PIN_FAST]    = FAST_PULSE_INPUT;
    assign pin_raw[PIN_LEN_RST] = LEN_RESET_IN;
    assign pin_raw[PIN_CNT_RST] = CNT_RESET_IN;

    // Edges compare the second and third stages, never the first
    generate
        for (genvar i = 0; i < PIN_N; i++)
        begin : g_pin
            always_ff @(posedge SYS_CLK or negedge RESETN)
            begin
                if (!RESETN)
                begin
                    pin_meta[i] <= 1'b0;
                    pin_sync[i] <= 1'b0;
                    pin_prev[i] <= 1'b0;
                end
                else
                begin
                    pin_meta[i] <= pin_raw[i];
                    pin_sync[i] <= pin_meta[i];
                    pin_prev[i] <= pin_sync[i];
                end
            end
            assign pin_rise[i] = pin_sync[i] & ~pin_prev[i];
        end
    endgenerate

    // High-rate sources may be steered to the fast terminal
    wire len_edge = LEN_FAST_SEL ? pin_rise[PIN_FAST]
                                 : pin_rise[PIN_LEN];
    wire cnt_edge = CNT_FAST_SEL ? pin_rise[PIN_FAST]
                                 : pin_rise[PIN_CNT];
    wire len_clr  = pin_rise[PIN_LEN_RST];
    wire cnt_clr  = pin_rise[PIN_CNT_RST];

    // Setting clamps and time base
    wire [PCT_W-1:0] swing_pct = (SWING_AMP > SWING_PCT_MAX)
                                 ? SWING_PCT_MAX : SWING_AMP;
    wire [PCT_W-1:0] jump_pct  = (JUMP_AMP > JUMP_PCT_MAX)
                                 ? JUMP_PCT_MAX : JUMP_AMP;
    wire [PCT_W-1:0] rise_pct  = (RISE_COEF > RISE_PCT_MAX)
                                 ? RISE_PCT_MAX : RISE_COEF;
    wire [TIME_W-1:0] cyc_t    = (CYCLE_TIME > CYCLE_MAX)
                                 ? CYCLE_MAX : CYCLE_TIME;

    // 0.1 s times 0.1 % lands exactly on the 100 us tick
    wire [SEG_W-1:0] cyc_ticks  = SEG_W'(cyc_t) * TICKS_PER_DS;
    wire [SEG_W-1:0] rise_ticks = SEG_W'(cyc_t) * SEG_W'(rise_pct);
    wire [SEG_W-1:0] fall_ticks = cyc_ticks - rise_ticks;

    wire swing_on = RUN & SWING_EN;

    logic [TICK_W-1:0] tick_cnt;
    logic              tick;

    // Tick divider; the swing phase only moves on this enable
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else
        begin
            tick     <= tick_cnt == TICK_W'(TICK_DIV - 1);
            tick_cnt <= (tick_cnt == TICK_W'(TICK_DIV - 1))
                        ? '0 : tick_cnt + 1'b1;
        end
    end

    // Triangle phase
    logic [SEG_W-1:0] phase;
    logic             falling;

    wire [SEG_W-1:0] seg_len  = falling ? fall_ticks : rise_ticks;
    wire             seg_end  = (phase + 1'b1) >= seg_len;

    // Segments alternate forever while swinging; idle parks at start
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            phase   <= SEG_RST;
            falling <= 1'b0;
        end
        else if (!swing_on)
        begin
            phase   <= SEG_RST;
            falling <= 1'b0;
        end
        else if (tick)
        begin
            phase   <= seg_end ? SEG_RST : phase + 1'b1;
            falling <= seg_end ? !falling : falling;
        end
    end

    // Divider job sequencer
    slcu_job_t        job;
    logic             div_start;
    logic             div_done;
    logic [NUM_W-1:0] div_quot;
    logic [SPAN_W-1:0] tri_step;
    logic [PULSE_W-1:0] len_pulses;
    logic             len_dirty;

    wire [FREQ_W-1:0] base = BASE_SEL ? MAX_FREQ : SET_FREQ;
    wire [SPAN_W-1:0] span2 = {SWING_SPAN, 1'b0} - SPAN_W'(JUMP_FREQ);
    wire [DEN_W-1:0] seg_den = (seg_len == '0) ? DEN_W'(1) : seg_len;
    wire [DEN_W-1:0] ppm_den = (PULSES_PER_M == '0)
                               ? DEN_W'(1) : DEN_W'(PULSES_PER_M);

    // Operands per job; all four share one divider
    wire [NUM_W-1:0] aw_num   = NUM_W'(base) * NUM_W'(swing_pct);
    wire [NUM_W-1:0] jump_num = NUM_W'(SWING_SPAN) * NUM_W'(jump_pct);
    wire [NUM_W-1:0] tri_num  = NUM_W'(span2) * NUM_W'(phase);
    wire [NUM_W-1:0] len_num  = NUM_W'(len_pulses) * LEN_SCALE;

    wire [NUM_W-1:0] div_num = (job == J_AW)   ? aw_num
                             : (job == J_JUMP) ? jump_num
                             : (job == J_TRI)  ? tri_num
                             : len_num;
    wire [DEN_W-1:0] div_den = (job == J_TRI) ? seg_den
                             : (job == J_LEN) ? ppm_den
                             : PERMILLE;

    slcu_divider u_div (
        .clk    (SYS_CLK),
        .resetn (RESETN),
        .start  (div_start),
        .num    (div_num),
        .den    (div_den),
        .done   (div_done),
        .quot   (div_quot)
    );

    // Results saturate rather than wrap
    wire quot_hi   = |div_quot[NUM_W-1:FREQ_W];
    wire [FREQ_W-1:0] quot16 = quot_hi ? '1 : div_quot[FREQ_W-1:0];
    wire [SPAN_W-1:0] quot17 = (|div_quot[NUM_W-1:SPAN_W])
                               ? '1 : div_quot[SPAN_W-1:0];

    // Round robin over the jobs, restarted on every completion
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            job       <= J_AW;
            div_start <= 1'b1;
        end
        else
        begin
            div_start <= div_done;
            if (div_done)
            begin
                case (job)
                    J_AW:    job <= J_JUMP;
                    J_JUMP:  job <= J_TRI;
                    J_TRI:   job <= J_LEN;
                    J_LEN:   job <= J_AW;
                    default: job <= J_AW;
                endcase
            end
        end
    end

    // Capture the span, jump and length quotients
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            SWING_SPAN    <= FREQ_RST;
            JUMP_FREQ     <= FREQ_RST;
            ACTUAL_LENGTH <= CNT_RST;
        end
        else if (len_clr)
        begin
            ACTUAL_LENGTH <= CNT_RST;
        end
        else if (div_done)
        begin
            if (job == J_AW)
                SWING_SPAN <= quot16;
            if (job == J_JUMP)
                JUMP_FREQ <= quot16;
            if (job == J_LEN && !len_dirty)
                ACTUAL_LENGTH <= quot16;
        end
    end

    // A clear or a turn while a job runs makes its result stale
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            len_dirty <= 1'b0;
        else if (len_clr || (tick && seg_end))
            len_dirty <= 1'b1;
        else if (div_start)
            len_dirty <= 1'b0;
    end

    // A turn restarts the step at zero so no old peak leaks across
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            tri_step <= SPAN_RST;
        else if (!swing_on || (tick && seg_end))
            tri_step <= SPAN_RST;
        else if (div_done && job == J_TRI && !len_dirty)
            tri_step <= quot17;
    end

    // Output frequency
    // Rise runs from -AW+jump up to +AW, fall from AW-jump down to -AW
    wire signed [OFF_W-1:0] aw_s   = $signed({3'b000, SWING_SPAN});
    wire signed [OFF_W-1:0] jump_s = $signed({3'b000, JUMP_FREQ});
    wire signed [OFF_W-1:0] step_s = $signed({2'b00, tri_step});
    wire signed [OFF_W-1:0] off_s  = falling
                                     ? aw_s - jump_s - step_s
                                     : jump_s - aw_s + step_s;
    wire signed [OFF_W-1:0] swing_s = $signed({3'b000, SET_FREQ})
                                      + off_s;
    wire signed [OFF_W-1:0] upper_s = $signed({3'b000, UPPER_LIMIT});
    wire signed [OFF_W-1:0] lower_s = $signed({3'b000, LOWER_LIMIT});

    wire [FREQ_W-1:0] clamped = (swing_s > upper_s) ? UPPER_LIMIT
                              : (swing_s < lower_s) ? LOWER_LIMIT
                              : swing_s[FREQ_W-1:0];

    // Zero amplitude leaves the set frequency untouched
    wire no_swing = !swing_on || swing_pct == '0;
    wire [FREQ_W-1:0] next_out_freq = no_swing ? SET_FREQ : clamped;

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            OUT_FREQ <= FREQ_RST;
        else
            OUT_FREQ <= next_out_freq;
    end

    // Length pulses and reached flag
    // A pulse in the clearing cycle still counts as the first one
    wire [PULSE_W-1:0] next_len_pulses =
        len_clr ? PULSE_W'(len_edge)
        : (len_edge && len_pulses != '1) ? len_pulses + 1'b1
        : len_pulses;

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            len_pulses     <= PULSE_RST;
            LENGTH_REACHED <= 1'b0;
        end
        else
        begin
            len_pulses     <= next_len_pulses;
            LENGTH_REACHED <= !len_clr &&
                              ACTUAL_LENGTH > SET_LENGTH;
        end
    end

    // General counter
    wire cnt_room = COUNT_VALUE < SET_COUNT;
    wire [CNT_W-1:0] next_count =
        cnt_clr ? CNT_W'(cnt_edge)
        : (cnt_edge && cnt_room) ? COUNT_VALUE + 1'b1
        : COUNT_VALUE;

    // Flags follow the count, so they hold until the count is cleared
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            COUNT_VALUE         <= CNT_RST;
            SET_COUNT_REACHED   <= 1'b0;
            DESIG_COUNT_REACHED <= 1'b0;
        end
        else
        begin
            COUNT_VALUE         <= next_count;
            SET_COUNT_REACHED   <= next_count >= SET_COUNT;
            DESIG_COUNT_REACHED <= next_count >= DESIG_COUNT;
        end
    end

endmodule
`default_nettype wire

/* File: verif/slcu_top_assertions.sv */
// Port-level checker for the swing, length and count unit
`timescale 1ns/100ps
`default_nettype none
module slcu_chk
    import slcu_pkg::*;
(
    input wire logic              SYS_CLK,
    input wire logic              RESETN,
    input wire logic              RUN,
    input wire logic              SWING_EN,
    input wire logic [FREQ_W-1:0] SET_FREQ,
    input wire logic [FREQ_W-1:0] UPPER_LIMIT,
    input wire logic [FREQ_W-1:0] LOWER_LIMIT,
    input wire logic [PCT_W-1:0]  SWING_AMP,
    input wire logic [CNT_W-1:0]  SET_LENGTH,
    input wire logic [CNT_W-1:0]  SET_COUNT,
    input wire logic [CNT_W-1:0]  DESIG_COUNT,
    input wire logic [FREQ_W-1:0] OUT_FREQ,
    input wire logic [CNT_W-1:0]  ACTUAL_LENGTH,
    input wire logic              LENGTH_REACHED,
    input wire logic [CNT_W-1:0]  COUNT_VALUE,
    input wire logic              SET_COUNT_REACHED,
    input wire logic              DESIG_COUNT_REACHED
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // Swing output follows the centre whenever it is parked
    AST_IDLE_CENTRE: assert property (!RUN || !SWING_EN |=>
        OUT_FREQ == $past(SET_FREQ)) else $error("Output off centre idle");
    AST_ZERO_AMP: assert property ((SWING_AMP == 10'h000) [*2] |->
        OUT_FREQ == $past(SET_FREQ)) else $error("Zero swing moved output");
    // Limits must hold two samples since the output is registered
    AST_CLAMP: assert property ((RUN && SWING_EN && SWING_AMP != 10'h000
        && LOWER_LIMIT <= UPPER_LIMIT && $stable(UPPER_LIMIT)
        && $stable(LOWER_LIMIT)) [*2] |-> OUT_FREQ <= UPPER_LIMIT
        && OUT_FREQ >= LOWER_LIMIT) else $error("Swing left limits");
    // Counter moves by one, or restarts low after a clear
    AST_COUNT_STEP: assert property (COUNT_VALUE != $past(COUNT_VALUE)
        |-> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001
        || COUNT_VALUE <= 16'h0001) else $error("Count jumped");
    AST_STOP_AT_SET: assert property (SET_COUNT_REACHED &&
        $stable(SET_COUNT) |=> COUNT_VALUE <= $past(COUNT_VALUE)
        || COUNT_VALUE == 16'h0001) else $error("Count ran past set");
    // Flags move on the same edge as the counter
    AST_SET_FLAG: assert property (SET_COUNT_REACHED ==
        (COUNT_VALUE >= $past(SET_COUNT)))
        else $error("Set count flag wrong");
    AST_DESIG_FLAG: assert property (DESIG_COUNT_REACHED ==
        (COUNT_VALUE >= $past(DESIG_COUNT)))
        else $error("Designated flag wrong");
    AST_LEN_FLAG: assert property ($rose(LENGTH_REACHED) |->
        $past(ACTUAL_LENGTH) > $past(SET_LENGTH))
        else $error("Length flag rose early");
    AST_FLAG_HOLD: assert property ($fell(SET_COUNT_REACHED) &&
        $stable(SET_COUNT) |-> COUNT_VALUE <= 16'h0001)
        else $error("Set flag dropped uncleared");
endmodule
bind slcu_top slcu_chk chk_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .RUN(RUN), .SWING_EN(SWING_EN), .SET_FREQ(SET_FREQ),
    .UPPER_LIMIT(UPPER_LIMIT), .LOWER_LIMIT(LOWER_LIMIT),
    .SWING_AMP(SWING_AMP), .SET_LENGTH(SET_LENGTH), .SET_COUNT(SET_COUNT),
    .DESIG_COUNT(DESIG_COUNT), .OUT_FREQ(OUT_FREQ),
    .ACTUAL_LENGTH(ACTUAL_LENGTH), .LENGTH_REACHED(LENGTH_REACHED),
    .COUNT_VALUE(COUNT_VALUE), .SET_COUNT_REACHED(SET_COUNT_REACHED),
    .DESIG_COUNT_REACHED(DESIG_COUNT_REACHED));
`default_nettype wire

/* File: verif/slcu_pulse_src.sv */
// Pulse train source standing in for one digital input terminal
`timescale 1ns/100ps
`default_nettype none
module slcu_pulse_src
(
    input  wire logic clk,
    output var  logic pin
);
    // Idle low; high lasts two samples, low at least two, so the synchroniser
    // never drops an edge, which a real terminal cannot promise either
    initial pin = 1'b0;
    task automatic send(input int n);
        repeat (n)
        begin
            @(negedge clk) pin = 1'b1;
            repeat (2) @(negedge clk);
            pin = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: verif/slcu_top_tb.sv */
// Self-checking bench for the swing, length and count unit
`timescale 1ns/100ps
`default_nettype none
module slcu_top_tb;
    import slcu_pkg::*;
    logic        clk, resetn, run, swing_en, base_sel;
    logic        len_fast_sel, cnt_fast_sel;
    logic [15:0] set_freq, max_freq, upper_limit, lower_limit;
    logic [9:0]  swing_amp, jump_amp, rise_coef;
    logic [14:0] cycle_time;
    logic [15:0] set_length, pulses_per_m, set_count, desig_count;
    wire  logic  len_pin, cnt_pin, fast_pin, lrst_pin, crst_pin;
    logic [15:0] out_freq, swing_span, jump_freq, actual_length, count_value;
    logic        length_reached, set_reached, desig_reached;
    int          mismatches, checks_done;

    // Short tick so a full swing period is ten thousand cycles
    slcu_top #(.TICK_DIV(10)) dut_u (
        .SYS_CLK(clk), .RESETN(resetn), .RUN(run), .SWING_EN(swing_en),
        .BASE_SEL(base_sel), .SET_FREQ(set_freq), .MAX_FREQ(max_freq),
        .UPPER_LIMIT(upper_limit), .LOWER_LIMIT(lower_limit),
        .SWING_AMP(swing_amp), .JUMP_AMP(jump_amp), .CYCLE_TIME(cycle_time),
        .RISE_COEF(rise_coef), .SET_LENGTH(set_length),
        .PULSES_PER_M(pulses_per_m), .SET_COUNT(set_count),
        .DESIG_COUNT(desig_count), .LEN_FAST_SEL(len_fast_sel),
        .CNT_FAST_SEL(cnt_fast_sel), .LEN_PULSE_IN(len_pin),
        .CNT_PULSE_IN(cnt_pin), .FAST_PULSE_INPUT(fast_pin),
        .LEN_RESET_IN(lrst_pin), .CNT_RESET_IN(crst_pin),
        .OUT_FREQ(out_freq), .SWING_SPAN(swing_span), .JUMP_FREQ(jump_freq),
        .ACTUAL_LENGTH(actual_length), .LENGTH_REACHED(length_reached),
        .COUNT_VALUE(count_value), .SET_COUNT_REACHED(set_reached),
        .DESIG_COUNT_REACHED(desig_reached));

    // Terminal sources; high-rate pulses share the fast input
    slcu_pulse_src len_u (.clk(clk), .pin(len_pin));
    slcu_pulse_src cnt_u (.clk(clk), .pin(cnt_pin));
    slcu_pulse_src fast_u (.clk(clk), .pin(fast_pin));
    slcu_pulse_src lrst_u (.clk(clk), .pin(lrst_pin));
    slcu_pulse_src crst_u (.clk(clk), .pin(crst_pin));

    // Free-running 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Compare helpers, case equality so an unknown never matches a known value
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask

    // Length refreshes once per divider round, so poll with a bound
    task automatic wait_len(input logic [15:0] exp);
        int i;
        for (i = 0; i < 1000 && actual_length !== exp; i++)
            @(negedge clk);
        if (i == 1000)
        begin
            mismatches++;
            end_sim();
        end
    endtask

    // Record extremes over 12000 cycles, just over one swing period, and when each was first seen
    task automatic measure(output logic [15:0] hi, output logic [15:0] lo,
                           output int thi, output int tlo);
        hi = 16'h0000;
        lo = 16'hFFFF;
        for (int i = 0; i < 12000; i++)
        begin
            @(negedge clk);
            if (out_freq > hi)
            begin
                hi = out_freq;
                thi = i;
            end
            if (out_freq < lo)
            begin
                lo = out_freq;
                tlo = i;
            end
        end
    endtask

    task automatic sc_idle();
        run = 1'b1;
        repeat (3) @(negedge clk);
        chk_val(out_freq, set_freq);
        swing_en = 1'b1;
        repeat (400) @(negedge clk);
        chk_val(out_freq, set_freq);
        chk_val(swing_span, 16'h0000);
    endtask

    task automatic sc_span();
        logic [15:0] exp_s;
        swing_amp = 10'h064;
        for (int b = 0; b < 2; b++)
        begin
            base_sel = b[0];
            jump_amp = b[0] ? 10'h1F4 : 10'h0C8;
            repeat (450) @(negedge clk);
            exp_s = 16'((b == 1 ? 32'(max_freq) : 32'(set_freq))
                * 32'(swing_amp) / 32'h3E8);
            chk_val(swing_span, exp_s);
            chk_val(jump_freq, 16'(32'(exp_s) * 32'(jump_amp) / 32'h3E8));
        end
        base_sel = 1'b0;
        jump_amp = 10'h0C8;
    endtask

    // Span 500 around 5000, jump 100; period 10000 cycles, rise half
    task automatic sc_swing();
        logic [15:0] hi, lo;
        int          thi, tlo;
        run = 1'b0;
        repeat (450) @(negedge clk);
        run = 1'b1;
        measure(hi, lo, thi, tlo);
        chk_bit(hi <= 16'h157C && hi > 16'h152C, 1'b1);
        chk_bit(lo >= 16'h1194 && lo < 16'h11E4, 1'b1);
        chk_bit(thi > 32'h11F8 && thi < 32'h1518, 1'b1);
        chk_bit(tlo > 32'h2580 && tlo < 32'h28A0, 1'b1);
        upper_limit = 16'h1482;
        lower_limit = 16'h128E;
        measure(hi, lo, thi, tlo);
        chk_val(hi, 16'h1482);
        chk_val(lo, 16'h128E);
        run = 1'b0;
    endtask

    // Designated at 3, set at 5; extra pulses past set are ignored
    task automatic sc_count();
        cnt_u.send(2);
        repeat (3) @(negedge clk);
        chk_val(count_value, 16'h0002);
        chk_bit(desig_reached, 1'b0);
        cnt_u.send(1);
        repeat (3) @(negedge clk);
        chk_bit(desig_reached, 1'b1);
        chk_bit(set_reached, 1'b0);
        cnt_u.send(4);
        repeat (3) @(negedge clk);
        chk_val(count_value, 16'h0005);
        chk_bit(set_reached, 1'b1);
        crst_u.send(1);
        chk_val(count_value, 16'h0000);
        chk_bit(set_reached | desig_reached, 1'b0);
        set_count = 16'h0001;
        desig_count = 16'h0001;
        cnt_fast_sel = 1'b1;
        fast_u.send(1);
        repeat (3) @(negedge clk);
        chk_val(count_value, 16'h0001);
        chk_bit(set_reached, 1'b1);
        cnt_fast_sel = 1'b0;
    endtask

    // Two pulses per metre; set length 2
    task automatic sc_length();
        len_u.send(3);
        wait_len(16'(32'h3 * 32'hA / 32'(pulses_per_m)));
        chk_val(actual_length, 16'h0001);
        chk_bit(length_reached, 1'b0);
        len_u.send(3);
        wait_len(16'(32'h6 * 32'hA / 32'(pulses_per_m)));
        repeat (2) @(negedge clk);
        chk_bit(length_reached, 1'b1);
        lrst_u.send(1);
        chk_val(actual_length, 16'h0000);
        chk_bit(length_reached, 1'b0);
        pulses_per_m = 16'h000A;
        set_length = 16'h0003;
        len_fast_sel = 1'b1;
        fast_u.send(4);
        wait_len(16'h0004);
        chk_val(actual_length, 16'h0004);
    endtask

    // Settings at time zero, ten cycles of reset, then the scenarios
    initial
    begin
        mismatches = 0;
        checks_done = 0;
        resetn = 1'b0;
        {run, swing_en, base_sel, len_fast_sel, cnt_fast_sel} = 5'h00;
        set_freq = 16'h1388;
        max_freq = 16'h2710;
        upper_limit = 16'hFFFF;
        lower_limit = 16'h0000;
        swing_amp = 10'h000;
        jump_amp = 10'h0C8;
        rise_coef = 10'h1F4;
        cycle_time = 15'h0001;
        set_length = 16'h0002;
        pulses_per_m = 16'h0014;
        set_count = 16'h0005;
        desig_count = 16'h0003;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        sc_idle();
        sc_span();
        sc_swing();
        sc_count();
        sc_length();
        end_sim();
    end
endmodule
`default_nettype wire
